// file: common/flprot_map.vh
// Purpose: Constants of the flash protection and option-bit block.
// Assumes: 32-bit AHB-Lite register port, word aligned.
// Notes:   Offsets are byte addresses.
`ifndef FLPROT_MAP_VH
`define FLPROT_MAP_VH
// ==========================================================
// Geometry
`define FLP_NLOCK         32
`define FLP_LKW           5
`define FLP_PAGE_BYTES    256
`define FLP_REGION_PAGES  64
`define FLP_REGION_SHIFT  14
// ==========================================================
// Register offsets
`define FLP_OFF_CMD       8'h00
`define FLP_OFF_STATUS    8'h04
`define FLP_OFF_LOCK      8'h08
`define FLP_OFF_OPTION    8'h0C
`define FLP_OFF_IRQ_STAT  8'h10
`define FLP_OFF_IRQ_MASK  8'h14
`define FLP_OFF_TARGET    8'h18
// ==========================================================
// Command codes, low byte of the command register
`define FLP_CMD_PROG      8'h01
`define FLP_CMD_SETLOCK   8'h02
`define FLP_CMD_CLRLOCK   8'h04
`define FLP_CMD_PAGE_ERASE 8'h05
`define FLP_CMD_FULL_ERASE 8'h08
`define FLP_CMD_SETGEN    8'h0B
`define FLP_CMD_CLRGEN    8'h0D
`define FLP_CMD_SETSEC    8'h0F
// ==========================================================
// Fields
`define FLP_ARG_LSB       8
`define FLP_GEN_BOD       0
`define FLP_GEN_BODRST    1
`define FLP_GEN_BOOT      2
`define FLP_OPT_SEC       3
`define FLP_OPT_FPM       4
`define FLP_IRQ_DONE      0
`define FLP_IRQ_LOCKERR   1
`define FLP_IRQ_CMDERR    2
// ==========================================================
// Calibration default and option-bit reset value
`define FLP_CALIB_DEF     8'hA5
`define FLP_GEN_RST       3'h0
// ==========================================================
// Bus encodings
`define FLP_HTRANS_NONSEQ 2'h2
`define FLP_HTRANS_SEQ    2'h3
`define FLP_HSIZE_WORD    3'h2
`endif

// file: logic/flprot_top.v
// Purpose: Lock bits, security bit, option bits and fast-programming entry of a flash controller.
// Assumes: hclk at 40 MHz; nonvolatile values reach this block through nv_* inputs at power-up.
// Notes:   Erase and program commands only check protection here; the array sequencer is outside.
`timescale 1ns/100ps
`include "flprot_map.vh"

module flprot_top #(
  parameter [1:0] CONFIG = 2'h2                 // 0: 8 regions, 1: 16 regions, 2 or 3: 32 regions
) (
  input  wire        hclk,                      // System clock
  input  wire        hresetn,                   // Asynchronous reset, active low
  input  wire        clk_en,                    // Freezes all state while low
  input  wire        hsel,                      // Slave select
  input  wire [31:0] haddr,                     // Byte address
  input  wire [1:0]  htrans,                    // Transfer type
  input  wire        hwrite,                    // Write when high
  input  wire [2:0]  hsize,                     // Transfer size
  input  wire [31:0] hwdata,                    // Write data
  input  wire        hready,                    // Bus ready
  output reg  [31:0] hrdata,                    // Read data
  output reg         hreadyout,                 // Slave ready
  output reg         hresp,                     // Response, always OKAY
  input  wire        nv_load,                   // Pulse: nonvolatile contents valid after power-up
  input  wire [31:0] nv_lock,                   // Stored lock bits
  input  wire [2:0]  nv_general,                // Stored general option bits
  input  wire        nv_security,               // Stored security bit
  input  wire        erase_pin,                 // External erase pin, async
  input  wire        test_mode_pin,             // Test pin, async
  input  wire        port_a_line_zero,          // Port A line 0, async
  input  wire        port_a_line_one,           // Port A line 1, async
  input  wire        full_erase_done,           // Pulse from array sequencer: full erase finished
  input  wire        fpp_req,                   // Fast port command request, same clock
  input  wire [7:0]  fpp_cmd,                   // Fast port command code
  input  wire [31:0] fpp_arg,                   // Fast port address or bit number
  input  wire        dbg_req,                   // Debug interface flash access request
  output reg         fpp_grant,                 // Fast port command accepted
  output reg         fpp_refuse,                // Fast port command refused
  output reg         dbg_grant,                 // Debug flash access allowed
  output reg         array_start,               // Pulse: start program or erase on the array
  output reg  [7:0]  array_cmd,                 // Command for the array
  output reg  [31:0] array_addr,                // Target byte address for the array
  output reg         brownout_detector_en,      // Brownout detector enable
  output reg         brownout_reset_en,         // Brownout reset enable
  output reg         boot_from_flash,           // Boot source select
  output reg  [7:0]  calib_bits,                // Factory calibration bits
  output reg         fast_prog_mode,            // Fast programming mode active
  output reg         irq                        // Level interrupt
);

  // ==========================================================
  // Functions
  function [`FLP_LKW-1:0] region_of;
    input [31:0] addr;
    begin
      region_of = addr[`FLP_REGION_SHIFT+`FLP_LKW-1:`FLP_REGION_SHIFT];
    end
  endfunction

  function [31:0] lock_impl_mask;
    input [1:0] cfg;
    begin
      case (cfg)
        2'h0:    lock_impl_mask = 32'h000000FF;
        2'h1:    lock_impl_mask = 32'h0000FFFF;
        default: lock_impl_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  localparam [31:0] IMPL = lock_impl_mask(CONFIG);

  // ==========================================================
  // Pin synchronisers
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  wire erase_s = sync2_ff[0];
  wire fpm_s   = sync2_ff[1] & sync2_ff[2] & sync2_ff[3];

  // ==========================================================
  // State
  reg [31:0] lock_ff;
  reg [2:0]  gen_ff;
  reg        sec_ff;
  reg        erase_seen_ff;
  reg [2:0]  irq_stat_ff;
  reg [2:0]  irq_mask_ff;
  reg [31:0] target_ff;
  reg [7:0]  last_cmd_ff;
  reg        wr_pend_ff;
  reg [7:0]  wr_addr_ff;

  // ==========================================================
  // Command arbitration: a fast port command takes priority over a register write.
  wire        ahb_go   = hsel & hready & (htrans == `FLP_HTRANS_NONSEQ || htrans == `FLP_HTRANS_SEQ);
  wire        sw_cmd   = wr_pend_ff && (wr_addr_ff == `FLP_OFF_CMD);
  wire        fp_cmd   = fpp_req && fast_prog_mode && !sec_ff;
  wire        any_cmd  = fp_cmd | sw_cmd;
  wire [7:0]  cmd      = fp_cmd ? fpp_cmd : hwdata[7:0];
  wire [31:0] arg      = fp_cmd ? fpp_arg : (hwdata >> `FLP_ARG_LSB);
  wire [31:0] tgt      = fp_cmd ? fpp_arg : target_ff;
  wire [`FLP_LKW-1:0] reg_ix = region_of(tgt);
  wire [`FLP_LKW-1:0] lk_ix  = arg[`FLP_LKW-1:0];
  wire        is_wrop  = (cmd == `FLP_CMD_PROG) || (cmd == `FLP_CMD_PAGE_ERASE);
  wire        is_full  = (cmd == `FLP_CMD_FULL_ERASE);
  wire        locked   = lock_ff[reg_ix];
  wire        any_lock = |lock_ff;
  wire        lock_err = any_cmd && ((is_wrop && locked) || (is_full && any_lock));
  wire        known    = is_wrop || is_full || cmd == `FLP_CMD_SETLOCK || cmd == `FLP_CMD_CLRLOCK ||
                         cmd == `FLP_CMD_SETGEN || cmd == `FLP_CMD_CLRGEN || cmd == `FLP_CMD_SETSEC;
  wire        bad_arg  = ((cmd == `FLP_CMD_SETGEN || cmd == `FLP_CMD_CLRGEN) && arg > 32'h2) ||
                         ((cmd == `FLP_CMD_SETLOCK || cmd == `FLP_CMD_CLRLOCK) && !IMPL[lk_ix]);
  wire        cmd_err  = any_cmd && (!known || bad_arg);
  wire        cmd_ok   = any_cmd && !cmd_err && !lock_err;

  wire [2:0]  irq_ev   = {cmd_err, lock_err, cmd_ok};
  wire        w1c      = wr_pend_ff && (wr_addr_ff == `FLP_OFF_IRQ_STAT);
  wire [2:0]  nxt_irq_stat = irq_ev | (irq_stat_ff & ~(w1c ? hwdata[2:0] : 3'h0));

  // ==========================================================
  // Sequential logic
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff      <= 4'h0;
      sync2_ff      <= 4'h0;
      lock_ff       <= 32'h00000000;
      gen_ff        <= `FLP_GEN_RST;
      sec_ff        <= 1'b0;
      erase_seen_ff <= 1'b0;
      irq_stat_ff   <= 3'h0;
      irq_mask_ff   <= 3'h0;
      target_ff     <= 32'h00000000;
      last_cmd_ff   <= 8'h00;
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 8'h00;
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      fpp_grant     <= 1'b0;
      fpp_refuse    <= 1'b0;
      dbg_grant     <= 1'b0;
      array_start   <= 1'b0;
      array_cmd     <= 8'h00;
      array_addr    <= 32'h00000000;
      brownout_detector_en <= 1'b0;
      brownout_reset_en    <= 1'b0;
      boot_from_flash      <= 1'b0;
      calib_bits    <= 8'h00;
      fast_prog_mode <= 1'b0;
      irq           <= 1'b0;
    end else if (clk_en) begin
      sync1_ff <= {port_a_line_one, port_a_line_zero, test_mode_pin, erase_pin};
      sync2_ff <= sync1_ff;
      fast_prog_mode <= fpm_s;
      // Bus address phase is captured; the data phase always ends in one cycle.
      wr_pend_ff <= ahb_go && hwrite && (hsize == `FLP_HSIZE_WORD);
      wr_addr_ff <= haddr[7:0];
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (wr_pend_ff && wr_addr_ff == `FLP_OFF_IRQ_MASK)
        irq_mask_ff <= hwdata[2:0];
      if (wr_pend_ff && wr_addr_ff == `FLP_OFF_TARGET)
        target_ff <= hwdata;
      irq_stat_ff <= nxt_irq_stat;
      irq         <= |(nxt_irq_stat & irq_mask_ff);
      array_start <= 1'b0;
      if (any_cmd)
        last_cmd_ff <= cmd;
      if (cmd_ok) begin
        case (cmd)
          `FLP_CMD_SETLOCK: lock_ff[lk_ix] <= 1'b1;
          `FLP_CMD_CLRLOCK: lock_ff[lk_ix] <= 1'b0;
          `FLP_CMD_SETGEN:  gen_ff[arg[1:0]] <= 1'b1;
          `FLP_CMD_CLRGEN:  gen_ff[arg[1:0]] <= 1'b0;
          `FLP_CMD_SETSEC:  sec_ff <= 1'b1;
          default: begin
            array_start <= 1'b1;
            array_cmd   <= cmd;
            array_addr  <= tgt;
          end
        endcase
      end
      fpp_grant  <= fp_cmd && cmd_ok;
      fpp_refuse <= fpp_req && !(fp_cmd && cmd_ok);
      dbg_grant  <= dbg_req && !sec_ff;
      // Erase pin clears locks and option bits while held; calibration is never touched.
      if (erase_s) begin
        lock_ff       <= 32'h00000000;
        gen_ff        <= `FLP_GEN_RST;
        erase_seen_ff <= 1'b1;
      end
      // A pin still held high keeps the pending mark set, so the set wins over the clear.
      if (erase_seen_ff && full_erase_done) begin
        sec_ff        <= 1'b0;
        if (!erase_s)
          erase_seen_ff <= 1'b0;
      end
      if (nv_load) begin
        lock_ff <= nv_lock & IMPL;
        gen_ff  <= nv_general;
        sec_ff  <= nv_security;
      end
      brownout_detector_en <= gen_ff[`FLP_GEN_BOD];
      brownout_reset_en    <= gen_ff[`FLP_GEN_BODRST];
      boot_from_flash      <= gen_ff[`FLP_GEN_BOOT];
      calib_bits           <= `FLP_CALIB_DEF;
      if (ahb_go && !hwrite) begin
        case (haddr[7:0])
          `FLP_OFF_CMD:      hrdata <= {24'h000000, last_cmd_ff};
          `FLP_OFF_STATUS:   hrdata <= {18'h00000, calib_bits, erase_seen_ff, fast_prog_mode, sec_ff, gen_ff};
          `FLP_OFF_LOCK:     hrdata <= lock_ff;
          `FLP_OFF_OPTION:   hrdata <= {29'h00000000, gen_ff};
          `FLP_OFF_IRQ_STAT: hrdata <= {29'h00000000, irq_stat_ff};
          `FLP_OFF_IRQ_MASK: hrdata <= {29'h00000000, irq_mask_ff};
          `FLP_OFF_TARGET:   hrdata <= target_ff;
          default:           hrdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: test/flprot_assertions.sv
// Purpose: Port-level checks of the flash protection block.
// Assumes: One clock, hclk, and reset hresetn, active low.
// Notes:   Bound to the top module from the bench top file.
`timescale 1ns/100ps
`include "flprot_map.vh"
module flprot_check (
  input wire       hclk,                 // Clock
  input wire       hresetn,              // Reset
  input wire       hreadyout,            // Ready
  input wire       hresp,                // Response
  input wire       dbg_req,              // Debug request
  input wire       dbg_grant,            // Debug grant
  input wire       fpp_req,              // Fast request
  input wire       fpp_grant,            // Fast grant
  input wire       fpp_refuse,           // Fast refusal
  input wire       test_mode_pin,        // Test pin
  input wire       port_a_line_zero,     // Port line 0
  input wire       port_a_line_one,      // Port line 1
  input wire       fast_prog_mode,       // Fast mode
  input wire [7:0] calib_bits,           // Calibration
  input wire       erase_pin,            // Erase pin
  input wire       brownout_detector_en, // Option 0
  input wire       brownout_reset_en,    // Option 1
  input wire       boot_from_flash       // Option 2
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire pins = test_mode_pin & port_a_line_zero & port_a_line_one;
  wire opts = brownout_detector_en | brownout_reset_en | boot_from_flash;
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("ready dropped");
  calib_fixed_a: assert property (calib_bits == `FLP_CALIB_DEF |=> calib_bits == `FLP_CALIB_DEF)
    else $error("calibration changed");
  dbg_cause_a: assert property (dbg_grant |-> $past(dbg_req))
    else $error("debug grant without request");
  fpp_answer_a: assert property (fpp_req |=> fpp_grant != fpp_refuse)
    else $error("fast port answer missing");
  fpp_outside_a: assert property (!fast_prog_mode && fpp_req |=> fpp_refuse)
    else $error("fast port served outside fast mode");
  fast_enter_a: assert property (pins [*4] |=> fast_prog_mode)
    else $error("fast mode not entered");
  fast_leave_a: assert property (!pins [*4] |=> !fast_prog_mode)
    else $error("fast mode without pins");
  erase_opts_a: assert property (erase_pin [*6] |-> !opts)
    else $error("option bit survived erase pin");
  cover property (fpp_req ##1 fpp_grant);
  cover property (dbg_req ##2 !dbg_grant);
  cover property ($fell(fast_prog_mode));
endmodule

// file: test/flprot_seq_model.sv
// Purpose: Array sequencer model answering full erase starts.
// Assumes: Same clock as the block.
// Notes:   DONE_DLY sets how slowly the erase completes.
`timescale 1ns/100ps
`include "flprot_map.vh"
module flprot_seq_model #(
  parameter int DONE_DLY = 6
) (
  input  wire       hclk,           // Clock
  input  wire       hresetn,        // Reset
  input  wire       array_start,    // Start pulse
  input  wire [7:0] array_cmd,      // Array command
  output logic      full_erase_done // Erase finished
);
  int cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      full_erase_done <= 1'b0;
    end else begin
      full_erase_done <= (cnt == 1);
      if (array_start && array_cmd == `FLP_CMD_FULL_ERASE)
        cnt <= DONE_DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// file: test/flprot_top_test.sv
// Purpose: Self-checking bench of the flash protection block.
// Assumes: Zero wait-state slave; hready fed from hreadyout.
// Notes:   Erase pin hold is short; the block counts no time.
`timescale 1ns/100ps
`include "flprot_map.vh"
module flprot_top_test;
  logic        hclk, hresetn = 0, hsel = 0, hwrite = 0, nv_load = 0, nv_security = 0, erase_pin = 0;
  logic        test_mode_pin = 0, port_a_line_zero = 0, port_a_line_one = 0, fpp_req = 0, dbg_req = 0;
  logic [31:0] haddr = 0, hwdata = 0, nv_lock = 0, fpp_arg = 0, hrdata, array_addr;
  logic [2:0]  hsize = 0, nv_general = 0;
  logic [1:0]  htrans = 0;
  logic [7:0]  fpp_cmd = 0, array_cmd, calib_bits;
  logic        hreadyout, hresp, fpp_grant, fpp_refuse, dbg_grant, array_start, full_erase_done, irq;
  logic        brownout_detector_en, brownout_reset_en, boot_from_flash, fast_prog_mode;
  int          fails = 0, checks = 0, starts = 0, cyc = 0, s;
  logic [7:0]  fcodes [5] = '{8'h01, 8'h05, 8'h08, 8'h02, 8'h04};
  wire  [2:0]  opt = {boot_from_flash, brownout_reset_en, brownout_detector_en};
  flprot_top flprot_top_i (.clk_en(1'b1), .hready(hreadyout), .*);
  flprot_seq_model flprot_seq_model_i (.*);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    starts <= starts + 32'(array_start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  // ==========================================================
  // Tasks
  task automatic final_report();
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `FLP_HTRANS_NONSEQ;
    haddr <= {24'h0, off};
    hwrite <= w;
    hsize <= `FLP_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, off, d, q);
  endtask
  task automatic rdc(input logic [7:0] off, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, off, 32'h0, q);
    chk(q & m, exp);
  endtask
  task automatic cmd(input logic [7:0] code, input logic [23:0] arg);
    wr(`FLP_OFF_CMD, {arg, code});
    tick(3);
  endtask
  task automatic fpp(input logic [7:0] c, input logic [1:0] exp);
    @(posedge hclk);
    fpp_req <= 1'b1;
    fpp_cmd <= c;
    @(posedge hclk);
    fpp_req <= 1'b0;
    @(posedge hclk);
    chk(32'({fpp_grant, fpp_refuse}), 32'(exp));
  endtask
  // ==========================================================
  // Sequence
  initial begin
    tick(16);
    hresetn <= 1'b1;
    rdc(`FLP_OFF_STATUS, 32'h2940, 32'h3FC0);
    rdc(8'h40, 32'h0, 32'hFFFFFFFF);
    nv_lock <= 32'h1;
    nv_general <= 3'h5;
    nv_load <= 1'b1;
    tick(1);
    nv_load <= 1'b0;
    rdc(`FLP_OFF_LOCK, 32'h1, 32'hFFFFFFFF);
    chk(32'(opt), 32'h5);
    cmd(`FLP_CMD_SETLOCK, 24'd3);
    cmd(`FLP_CMD_SETLOCK, 24'd31);
    rdc(`FLP_OFF_LOCK, 32'h80000009, 32'hFFFFFFFF);
    wr(`FLP_OFF_IRQ_MASK, 32'h7);
    wr(`FLP_OFF_TARGET, 32'hFFFC);
    s = starts;
    cmd(`FLP_CMD_PROG, 24'd0);
    chk(32'(starts - s), 32'h0);
    chk(32'(irq), 32'h1);
    rdc(`FLP_OFF_IRQ_STAT, 32'h2, 32'h2);
    wr(`FLP_OFF_IRQ_STAT, 32'h7);
    tick(1);
    chk(32'(irq), 32'h0);
    wr(`FLP_OFF_TARGET, 32'h10000);
    cmd(`FLP_CMD_PAGE_ERASE, 24'd0);
    chk(32'(starts - s), 32'h1);
    chk(array_addr, 32'h10000);
    cmd(`FLP_CMD_FULL_ERASE, 24'd0);
    chk(32'(starts - s), 32'h1);
    cmd(`FLP_CMD_CLRLOCK, 24'd3);
    rdc(`FLP_OFF_LOCK, 32'h80000001, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) begin
      cmd(`FLP_CMD_CLRGEN, 24'(i));
      chk(32'(opt[i]), 32'h0);
      cmd(`FLP_CMD_SETGEN, 24'(i));
      chk(32'(opt[i]), 32'h1);
    end
    cmd(`FLP_CMD_SETGEN, 24'd3);
    rdc(`FLP_OFF_IRQ_STAT, 32'h4, 32'h4);
    dbg_req <= 1'b1;
    tick(2);
    chk(32'(dbg_grant), 32'h1);
    cmd(`FLP_CMD_SETSEC, 24'd0);
    wr(`FLP_OFF_STATUS, 32'h0);
    chk(32'(dbg_grant), 32'h0);
    rdc(`FLP_OFF_STATUS, 32'h8, 32'h8);
    {test_mode_pin, port_a_line_zero, port_a_line_one} <= 3'h7;
    tick(5);
    chk(32'(fast_prog_mode), 32'h1);
    fpp(`FLP_CMD_SETLOCK, 2'b01);
    erase_pin <= 1'b1;
    tick(10);
    rdc(`FLP_OFF_LOCK, 32'h0, 32'hFFFFFFFF);
    chk(32'(opt), 32'h0);
    rdc(`FLP_OFF_STATUS, 32'h2948, 32'h3FC8);
    erase_pin <= 1'b0;
    tick(4);
    cmd(`FLP_CMD_FULL_ERASE, 24'd0);
    tick(10);
    rdc(`FLP_OFF_STATUS, 32'h0, 32'h8);
    chk(32'(dbg_grant), 32'h1);
    foreach (fcodes[i]) fpp(fcodes[i], 2'b10);
    {test_mode_pin, port_a_line_zero, port_a_line_one} <= 3'h3;
    tick(5);
    fpp(`FLP_CMD_PROG, 2'b01);
    final_report();
  end
endmodule
bind flprot_top flprot_check flprot_check_i (.*);
